// file: common/bf_consts.svh
// Offsets, field positions, reset values and timing counts of the breaker failure logic.
// Operation
// - Backup trip comes from status inputs combined with binary and enumerated settings.
// - Block input inhibits the function; no backup trip or retrip is produced.
// - Phase flag high while phase current exceeds setting 20 to 200 percent, default 30.
// - Residual flag high while 3I0 exceeds setting 10 to 200 percent, default 20.
// - Operation is Off, Current, Contact or both; default Off; Off disables.
// - Single-pole retrip enable, Off or On, default Off, gates per-phase retrips.
// - Retrip delay 0 to 1000 ms in 1 ms steps, default 100 ms.
// - Backup delay 100 to 60000 ms in 1 ms steps, default 1000 ms.
// - Pulse duration 0 to 60000 ms in 1 ms steps, default 100 ms.
// - Drive backup trip output and, single-pole, per-phase retrip outputs.
// - Each start rising edge launches backup and retrip timers, per phase.
// - Backup timer expiry with condition still present issues backup trip.
// - Every trip command stays high at least the pulse duration; the code drops them at once when block_in is high or Operation is Off.
// - With retrip on, retrip at retrip expiry in phases whose backup timer runs; the code retrips only when single_pole is also set.
`ifndef BF_CONSTS_SVH
`define BF_CONSTS_SVH
`define BF_ADDR_CTRL     8'h00
`define BF_ADDR_PH_SET   8'h04
`define BF_ADDR_RES_SET  8'h08
`define BF_ADDR_RT_DLY   8'h0C
`define BF_ADDR_BU_DLY   8'h10
`define BF_ADDR_PULSE    8'h14
`define BF_ADDR_STATUS   8'h18
`define BF_ADDR_IRQ_STAT 8'h1C
`define BF_ADDR_IRQ_MASK 8'h20
`define BF_CTRL_OP_LSB   0
`define BF_CTRL_RT_BIT   2
`define BF_CTRL_SP_BIT   3
`define BF_PH_MIN        16'h0014
`define BF_PH_MAX        16'h00C8
`define BF_PH_DEF        16'h001E
`define BF_RES_MIN       16'h000A
`define BF_RES_MAX       16'h00C8
`define BF_RES_DEF       16'h0014
`define BF_RT_MIN        16'h0000
`define BF_RT_MAX        16'h03E8
`define BF_RT_DEF        16'h0064
`define BF_BU_MIN        16'h0064
`define BF_BU_MAX        16'hEA60
`define BF_BU_DEF        16'h03E8
`define BF_PULSE_MIN     16'h0000
`define BF_PULSE_MAX     16'hEA60
`define BF_PULSE_DEF     16'h0064
`define BF_CLK_PERIOD_NS 4
`define BF_MS_NS         1000000
`define BF_MS_CYCLES     (`BF_MS_NS / `BF_CLK_PERIOD_NS)
`endif

// file: common/bf_pkg.sv
// Types shared by the breaker failure decision logic.
package bf_pkg;
   typedef enum logic [1:0] {
      OP_OFF     = 2'h0,
      OP_CURRENT = 2'h1,
      OP_CONTACT = 2'h2,
      OP_BOTH    = 2'h3
   } op_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_TRIP = 3'b100
   } chan_state_t;
   typedef struct packed {
      op_mode_t op;
      logic     retrip_en;
      logic     single_pole;
   } ctrl_t;
   typedef struct packed {
      chan_state_t st;
      logic [15:0] elapsed;
      logic [15:0] rt_pulse;
      logic [15:0] bu_pulse;
      logic        rt_done;
      logic        rt_on;
      logic        bu_on;
   } chan_t;
endpackage : bf_pkg

// file: hw/breaker_failure_decision_logic.sv
// Breaker failure decision logic with register port and interrupt.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "bf_consts.svh"
module breaker_failure_decision_logic
   import bf_pkg::*;
#(
   parameter int MS_CYCLES = `BF_MS_CYCLES
)(
   // Clock and reset.
   input  logic        mclk,
   input  logic        reset,
   // Register port.
   input  logic [7:0]  addr,
   input  logic [31:0] wdata,
   input  logic        wr,
   input  logic        rd,
   output logic [31:0] rdata,
   output logic        irq,
   // Status inputs.
   input  logic        block_in,
   input  logic        general_start_in,
   input  logic        residual_start_in,
   input  logic        start_ph1_in,
   input  logic        start_ph2_in,
   input  logic        start_ph3_in,
   input  logic        breaker_closed_in,
   input  logic        breaker_closed_ph1_in,
   input  logic        breaker_closed_ph2_in,
   input  logic        breaker_closed_ph3_in,
   // Current magnitudes in percent of nominal.
   input  logic [15:0] ph1_current_in,
   input  logic [15:0] ph2_current_in,
   input  logic [15:0] ph3_current_in,
   input  logic [15:0] residual_3i0_in,
   // Trip commands.
   output logic        backup_trip_out,
   output logic        retrip_ph1_out,
   output logic        retrip_ph2_out,
   output logic        retrip_ph3_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Out-of-range settings are pulled to the nearest legal value.
   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                           input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp16

   // Saturating increment keeps a stuck condition from wrapping a timer.
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : sat_inc

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   ctrl_t       ctrl_reg, ctrl_next;
   logic [15:0] ph_set_reg, ph_set_next, res_set_reg, res_set_next;
   logic [15:0] rt_dly_reg, rt_dly_next, bu_dly_reg, bu_dly_next;
   logic [15:0] pulse_reg, pulse_next;
   logic [4:0]  irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        irq_reg, irq_next;
   logic [31:0] tick_cnt_reg, tick_cnt_next;
   logic        tick_reg, tick_next;
   chan_t       ch_reg [3], ch_next [3];
   logic [2:0]  start_prev_reg, start_prev_next;
   logic        bu_out_reg, bu_out_next;
   logic [2:0]  rt_out_reg, rt_out_next;
   logic [2:0]  ph_over;
   logic        res_over;
   logic [2:0]  start_v, cur_v, cont_v, cond_v;
   logic        active;
   logic [4:0]  evt;

   ////////////////////////////////////////////////////////////////////////////
   // Comparators and channel conditions.

   // Strict compare: equal to the setting is not yet an overcurrent.
   always_comb begin
      ph_over[0] = ph1_current_in > ph_set_reg;
      ph_over[1] = ph2_current_in > ph_set_reg;
      ph_over[2] = ph3_current_in > ph_set_reg;
      res_over   = residual_3i0_in > res_set_reg;
   end

   // In common mode all three channels see the same start and condition.
   always_comb begin
      active = !block_in && (ctrl_reg.op != OP_OFF);
      for (int p = 0; p < 3; p++) begin
         if (ctrl_reg.single_pole) begin
            start_v[p] = general_start_in | (p == 0 ? start_ph1_in : (p == 1 ? start_ph2_in : start_ph3_in));
            cur_v[p]   = ph_over[p] | (res_over & residual_start_in);
            cont_v[p]  = (p == 0) ? breaker_closed_ph1_in :
                         ((p == 1) ? breaker_closed_ph2_in : breaker_closed_ph3_in);
         end else begin
            start_v[p] = general_start_in | residual_start_in;
            cur_v[p]   = (|ph_over) | (res_over & residual_start_in);
            cont_v[p]  = breaker_closed_in;
         end
         unique case (ctrl_reg.op)
            OP_CURRENT: cond_v[p] = cur_v[p];
            OP_CONTACT: cond_v[p] = cont_v[p];
            OP_BOTH:    cond_v[p] = cur_v[p] | cont_v[p];
            OP_OFF:     cond_v[p] = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond timebase.

   // The tick phase is free running, so delays carry up to one ms of jitter.
   always_comb begin
      tick_next     = 1'b0;
      tick_cnt_next = tick_cnt_reg + 32'h00000001;
      if (tick_cnt_reg == 32'(MS_CYCLES - 1)) begin
         tick_cnt_next = 32'h00000000;
         tick_next     = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg     <= 1'b0;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
         tick_reg     <= tick_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel timers and trip commands.

   // Pulses are handled before the state step so a fresh trip restarts them.
   always_comb begin
      evt = 5'h00;
      for (int p = 0; p < 3; p++) begin
         ch_next[p]         = ch_reg[p];
         start_prev_next[p] = start_v[p];
         if (ch_reg[p].rt_on) begin
            if (tick_reg)
               ch_next[p].rt_pulse = sat_inc(ch_reg[p].rt_pulse);
            if (ch_reg[p].rt_pulse >= pulse_reg && !cond_v[p])
               ch_next[p].rt_on = 1'b0;
         end
         if (ch_reg[p].bu_on) begin
            if (tick_reg)
               ch_next[p].bu_pulse = sat_inc(ch_reg[p].bu_pulse);
            if (ch_reg[p].bu_pulse >= pulse_reg && !cond_v[p])
               ch_next[p].bu_on = 1'b0;
         end
         if (!active) begin
            ch_next[p] = '{st: ST_IDLE, default: '0};
         end else begin
            unique case (ch_reg[p].st)
               ST_IDLE: begin
                  if (start_v[p] && !start_prev_reg[p]) begin
                     ch_next[p].st      = ST_RUN;
                     ch_next[p].elapsed = 16'h0000;
                     ch_next[p].rt_done = 1'b0;
                     evt[4]             = 1'b1;
                  end
               end
               ST_RUN: begin
                  if (!cond_v[p]) begin
                     ch_next[p].st = ST_IDLE;
                  end else begin
                     if (tick_reg)
                        ch_next[p].elapsed = sat_inc(ch_reg[p].elapsed);
                     if (ctrl_reg.single_pole && ctrl_reg.retrip_en && !ch_reg[p].rt_done &&
                         ch_reg[p].elapsed >= rt_dly_reg) begin
                        ch_next[p].rt_done  = 1'b1;
                        ch_next[p].rt_on    = 1'b1;
                        ch_next[p].rt_pulse = 16'h0000;
                        evt[p + 1]          = 1'b1;
                     end
                     if (ch_reg[p].elapsed >= bu_dly_reg) begin
                        ch_next[p].st       = ST_TRIP;
                        ch_next[p].bu_on    = 1'b1;
                        ch_next[p].bu_pulse = 16'h0000;
                        evt[0]              = 1'b1;
                     end
                  end
               end
               ST_TRIP: begin
                  if (!ch_reg[p].bu_on && !ch_reg[p].rt_on)
                     ch_next[p].st = ST_IDLE;
               end
               default: ch_next[p].st = ST_IDLE;
            endcase
         end
      end
      bu_out_next    = ch_next[0].bu_on | ch_next[1].bu_on | ch_next[2].bu_on;
      rt_out_next[0] = ch_next[0].rt_on;
      rt_out_next[1] = ch_next[1].rt_on;
      rt_out_next[2] = ch_next[2].rt_on;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int p = 0; p < 3; p++)
            ch_reg[p] <= '{st: ST_IDLE, default: '0};
         start_prev_reg <= 3'h0;
         bu_out_reg     <= 1'b0;
         rt_out_reg     <= 3'h0;
      end else begin
         for (int p = 0; p < 3; p++)
            ch_reg[p] <= ch_next[p];
         start_prev_reg <= start_prev_next;
         bu_out_reg     <= bu_out_next;
         rt_out_reg     <= rt_out_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port and interrupt.

   // Settings clamp on write; a new event wins over a same-cycle clear.
   always_comb begin
      ctrl_next     = ctrl_reg;
      ph_set_next   = ph_set_reg;
      res_set_next  = res_set_reg;
      rt_dly_next   = rt_dly_reg;
      bu_dly_next   = bu_dly_reg;
      pulse_next    = pulse_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      rdata_next    = 32'h00000000;
      if (wr) begin
         unique case (addr)
            `BF_ADDR_CTRL: begin
               ctrl_next.op          = op_mode_t'(wdata[`BF_CTRL_OP_LSB +: 2]);
               ctrl_next.retrip_en   = wdata[`BF_CTRL_RT_BIT];
               ctrl_next.single_pole = wdata[`BF_CTRL_SP_BIT];
            end
            `BF_ADDR_PH_SET:   ph_set_next = clamp16(wdata[15:0], `BF_PH_MIN, `BF_PH_MAX);
            `BF_ADDR_RES_SET:  res_set_next = clamp16(wdata[15:0], `BF_RES_MIN, `BF_RES_MAX);
            `BF_ADDR_RT_DLY:   rt_dly_next = clamp16(wdata[15:0], `BF_RT_MIN, `BF_RT_MAX);
            `BF_ADDR_BU_DLY:   bu_dly_next = clamp16(wdata[15:0], `BF_BU_MIN, `BF_BU_MAX);
            `BF_ADDR_PULSE:    pulse_next = clamp16(wdata[15:0], `BF_PULSE_MIN, `BF_PULSE_MAX);
            `BF_ADDR_IRQ_STAT: irq_stat_next = irq_stat_reg & ~wdata[4:0];
            `BF_ADDR_IRQ_MASK: irq_mask_next = wdata[4:0];
            default: ;
         endcase
      end
      irq_stat_next = irq_stat_next | evt;
      irq_next      = |(irq_stat_next & irq_mask_next);
      if (rd) begin
         unique case (addr)
            `BF_ADDR_CTRL:     rdata_next = {28'h0000000, ctrl_reg.single_pole, ctrl_reg.retrip_en, ctrl_reg.op};
            `BF_ADDR_PH_SET:   rdata_next = {16'h0000, ph_set_reg};
            `BF_ADDR_RES_SET:  rdata_next = {16'h0000, res_set_reg};
            `BF_ADDR_RT_DLY:   rdata_next = {16'h0000, rt_dly_reg};
            `BF_ADDR_BU_DLY:   rdata_next = {16'h0000, bu_dly_reg};
            `BF_ADDR_PULSE:    rdata_next = {16'h0000, pulse_reg};
            `BF_ADDR_STATUS:   rdata_next = {15'h0000, ch_reg[2].st, ch_reg[1].st, ch_reg[0].st,
                                             rt_out_reg, bu_out_reg, res_over, ph_over};
            `BF_ADDR_IRQ_STAT: rdata_next = {27'h0000000, irq_stat_reg};
            `BF_ADDR_IRQ_MASK: rdata_next = {27'h0000000, irq_mask_reg};
            default:           rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl_reg     <= '{op: OP_OFF, retrip_en: 1'b0, single_pole: 1'b0};
         ph_set_reg   <= `BF_PH_DEF;
         res_set_reg  <= `BF_RES_DEF;
         rt_dly_reg   <= `BF_RT_DEF;
         bu_dly_reg   <= `BF_BU_DEF;
         pulse_reg    <= `BF_PULSE_DEF;
         irq_stat_reg <= 5'h00;
         irq_mask_reg <= 5'h00;
         rdata_reg    <= 32'h00000000;
         irq_reg      <= 1'b0;
      end else begin
         ctrl_reg     <= ctrl_next;
         ph_set_reg   <= ph_set_next;
         res_set_reg  <= res_set_next;
         rt_dly_reg   <= rt_dly_next;
         bu_dly_reg   <= bu_dly_next;
         pulse_reg    <= pulse_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg    <= rdata_next;
         irq_reg      <= irq_next;
      end
   end

   // Outputs straight from flip-flops.
   assign rdata           = rdata_reg;
   assign irq             = irq_reg;
   assign backup_trip_out = bu_out_reg;
   assign retrip_ph1_out  = rt_out_reg[0];
   assign retrip_ph2_out  = rt_out_reg[1];
   assign retrip_ph3_out  = rt_out_reg[2];

endmodule : breaker_failure_decision_logic

// file: verification/fault_source.sv
// Model of the start sources and breaker contacts facing the decision logic.
`timescale 1ns/1ps
module fault_source (
   // Clock and scenario commands.
   input  logic        mclk,
   input  logic        fault,
   input  logic [1:0]  sel,
   input  logic        cur_on,
   input  logic        closed,
   input  logic        obey,
   input  logic        trip,
   // Inputs of the decision logic.
   output logic        general_start_in,
   output logic [2:0]  start_ph,
   output logic        cb_common,
   output logic [2:0]  cb_ph,
   output logic [15:0] cur
);
   logic [3:0] wait_cnt;
   logic       opened;
   logic [3:0] hot;
   // An obedient breaker opens eight cycles after a trip; a stuck one never does.
   always_ff @(posedge mclk) begin
      if (!fault) begin
         wait_cnt <= 4'h0;
         opened   <= 1'b0;
      end else if (trip && obey && !opened) begin
         wait_cnt <= wait_cnt + 4'h1;
         opened   <= (wait_cnt == 4'h7);
      end
   end
   // Select 0 is the general start, 1 to 3 a phase; currents drop below setting when the fault goes.
   assign hot              = fault ? (4'h1 << sel) : 4'h0;
   assign general_start_in = hot[0];
   assign start_ph         = hot[3:1];
   assign cb_common        = fault && closed && !opened;
   assign cb_ph            = cb_common ? hot[3:1] : 3'h0;
   assign cur              = (fault && cur_on) ? 16'h0032 : 16'h0005;
endmodule : fault_source

// file: verification/bf_chk.sv
// Port assertions for the breaker failure decision logic.
`timescale 1ns/1ps
module bf_chk #(
   parameter int MS_CYCLES = 4
)(
   // Clock, reset and register port.
   input logic        mclk,
   input logic        reset,
   input logic        wr,
   input logic        rd,
   input logic [31:0] rdata,
   input logic        irq,
   // Status inputs and trip commands.
   input logic        block_in,
   input logic        general_start_in,
   input logic        residual_start_in,
   input logic        start_ph1_in,
   input logic        start_ph2_in,
   input logic        start_ph3_in,
   input logic        backup_trip_out,
   input logic        retrip_ph1_out,
   input logic        retrip_ph2_out,
   input logic        retrip_ph3_out
);
   // The tick phase is free, so the shortest legal span is 99 whole ticks.
   localparam int MIN_CYC = 99 * MS_CYCLES;
   logic [3:0]  outs;
   logic        st_any;
   logic [15:0] hi_cnt [4];
   logic [15:0] st_cnt;
   assign outs   = {retrip_ph3_out, retrip_ph2_out, retrip_ph1_out, backup_trip_out};
   assign st_any = general_start_in | residual_start_in | start_ph1_in | start_ph2_in | start_ph3_in;
   // Saturating counts of how long each trip stands and of time since the latest start edge.
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         hi_cnt[i] <= (reset || !outs[i]) ? 16'h0000 : hi_cnt[i] + {15'h0000, hi_cnt[i] != 16'hFFFF};
      end
      st_cnt <= (reset || $rose(st_any)) ? 16'h0000 : st_cnt + {15'h0000, st_cnt != 16'hFFFF};
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   property p_block_clears; block_in |-> ##2 (outs == 4'h0); endproperty
   a_block_clears: assert property (p_block_clears) else $error("trip survives block");
   property p_rdata_idle; !rd |=> (rdata == 32'h0); endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   property p_reset_quiet; disable iff (1'b0) reset |=> (outs == 4'h0) && !irq; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output high after reset");
   property p_pulse_bu; $fell(backup_trip_out) |-> hi_cnt[0] >= MIN_CYC || $past(block_in); endproperty
   a_pulse_bu: assert property (p_pulse_bu) else $error("backup pulse too short");
   property p_pulse_rt; $fell(retrip_ph2_out) |-> hi_cnt[2] >= MIN_CYC || $past(block_in); endproperty
   a_pulse_rt: assert property (p_pulse_rt) else $error("retrip pulse too short");
   property p_bu_delay; $rose(backup_trip_out) |-> st_cnt >= MIN_CYC; endproperty
   a_bu_delay: assert property (p_bu_delay) else $error("backup trip too early");
   property p_rise_free; $rose(backup_trip_out) || $rose(retrip_ph2_out) |-> !$past(block_in); endproperty
   a_rise_free: assert property (p_rise_free) else $error("trip rose while blocked");
   property p_irq_fall; $fell(irq) |-> $past(wr); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
   c_bu: cover property ($rose(backup_trip_out));
   c_rt: cover property ($rose(retrip_ph2_out));
   c_irq: cover property ($rose(irq));
endmodule : bf_chk
bind breaker_failure_decision_logic bf_chk #(.MS_CYCLES(MS_CYCLES)) bf_chk_i (
   .mclk(mclk), .reset(reset), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .block_in(block_in),
   .general_start_in(general_start_in), .residual_start_in(residual_start_in), .start_ph1_in(start_ph1_in),
   .start_ph2_in(start_ph2_in), .start_ph3_in(start_ph3_in), .backup_trip_out(backup_trip_out),
   .retrip_ph1_out(retrip_ph1_out), .retrip_ph2_out(retrip_ph2_out), .retrip_ph3_out(retrip_ph3_out)
);

// file: verification/tb_breaker_failure_decision_logic.sv
// Self-checking bench for the breaker failure decision logic.
`timescale 1ns/1ps
module tb_breaker_failure_decision_logic import bf_pkg::*;;
   localparam int MS = 4;
   logic        mclk, irq, backup_trip_out, general_start_in, cb_common;
   logic        reset = 1'b1, wr = 1'b0, rd = 1'b0, block_in = 1'b0, fault = 1'b0;
   logic        cur_on = 1'b0, closed = 1'b0, obey = 1'b0, res_start = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic [2:0]  start_ph, cb_ph, rt;
   logic [3:0]  outs;
   logic [7:0]  addr = 8'h00;
   logic [15:0] cur, res_cur = 16'h0005;
   logic [31:0] wdata = 32'h0, rdata;
   int          err_total = 0, checks = 0;
   assign outs = {rt, backup_trip_out};
   breaker_failure_decision_logic #(.MS_CYCLES(MS)) breaker_failure_decision_logic_i (
      .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .block_in(block_in), .general_start_in(general_start_in), .residual_start_in(res_start),
      .start_ph1_in(start_ph[0]), .start_ph2_in(start_ph[1]), .start_ph3_in(start_ph[2]),
      .breaker_closed_in(cb_common), .breaker_closed_ph1_in(cb_ph[0]), .breaker_closed_ph2_in(cb_ph[1]),
      .breaker_closed_ph3_in(cb_ph[2]), .ph1_current_in(cur), .ph2_current_in(cur), .ph3_current_in(cur),
      .residual_3i0_in(res_cur), .backup_trip_out(backup_trip_out), .retrip_ph1_out(rt[0]),
      .retrip_ph2_out(rt[1]), .retrip_ph3_out(rt[2]));
   fault_source fault_source_i (
      .mclk(mclk), .fault(fault), .sel(sel), .cur_on(cur_on), .closed(closed), .obey(obey), .trip(|outs),
      .general_start_in(general_start_in), .start_ph(start_ph), .cb_common(cb_common), .cb_ph(cb_ph), .cur(cur));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Strobes drop after one cycle and a spare edge follows, so no strobe is assigned twice at once.
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
      @(posedge mclk);
   endtask : rd_reg
   // Outputs are sampled at the falling edge, clear of the flops' updates.
   task automatic wait_lvl(input int idx, input logic lvl, output int n);
      n = 0;
      @(negedge mclk);
      while (outs[idx] !== lvl && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      @(posedge mclk);
   endtask : wait_lvl
   task automatic chk_irq(input logic exp);
      @(negedge mclk);
      check("irq", irq, exp);
      @(posedge mclk);
   endtask : chk_irq
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0]  wa [7] = '{8'h04, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h14};
      logic [31:0] wd [7] = '{32'h12C, 32'h5, 32'h0, 32'h7D0, 32'hA, 32'hFFFF, 32'h64};
      logic [31:0] we [7] = '{32'hC8, 32'h14, 32'hA, 32'h3E8, 32'h64, 32'hEA60, 32'h64};
      logic [31:0] df [6] = '{32'h0, 32'h1E, 32'h14, 32'h64, 32'h3E8, 32'h64};
      logic [31:0] d;
      for (int i = 0; i < 6; i++) begin
         rd_reg(8'(i * 4), d);
         check("default", d, df[i]);
      end
      // Out-of-range settings clamp to the nearest limit.
      for (int i = 0; i < 7; i++) begin
         wr_reg(wa[i], wd[i]);
         rd_reg(wa[i], d);
         check("clamp", d, we[i]);
      end
      wr_reg(8'h24, 32'hFFFFFFFF);
      rd_reg(8'h24, d);
      check("unmapped", d, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_modes();
      int   n;
      logic exp;
      wr_reg(8'h20, 32'h1);
      for (int m = 0; m < 4; m++) begin
         exp = (m == 1) || (m == 3);
         wr_reg(8'h00, m);
         cur_on <= 1'b1;
         fault <= 1'b1;
         wait_lvl(0, 1'b1, n);
         check("mode trip", outs[0], exp);
         check("delay", (n >= 99 * MS && n <= 103 * MS) || !exp, 1'b1);
         check("irq", irq, exp);
         fault <= 1'b0;
         wait_lvl(0, 1'b0, n);
         check("pulse", n >= 98 * MS || !exp, 1'b1);
         wr_reg(8'h1C, 32'h1F);
         chk_irq(1'b0);
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_block();
      int n;
      wr_reg(8'h00, {30'h0, OP_CURRENT});
      fault <= 1'b1;
      wait_lvl(0, 1'b1, n);
      block_in <= 1'b1;
      wait_lvl(0, 1'b0, n);
      check("block drop", n <= 3, 1'b1);
      fault <= 1'b0;
      repeat (4) @(posedge mclk);
      fault <= 1'b1;
      wait_lvl(0, 1'b1, n);
      check("blocked", outs, 4'h0);
      fault <= 1'b0;
      block_in <= 1'b0;
      wr_reg(8'h1C, 32'h1F);
      $display("test block done");
   endtask : t_block
   task automatic t_retrip();
      int          n;
      logic [31:0] d;
      wr_reg(8'h0C, 32'hA);
      wr_reg(8'h20, 32'h0);
      for (int en = 1; en >= 0; en--) begin
         wr_reg(8'h00, {28'h0, 1'b1, 1'(en), OP_CONTACT});
         sel <= 2'h2;
         cur_on <= 1'b0;
         closed <= 1'b1;
         obey <= 1'(en);
         fault <= 1'b1;
         wait_lvl(en ? 2 : 0, 1'b1, n);
         if (en != 0) begin
            check("retrip delay", n >= 9 * MS && n <= 14 * MS, 1'b1);
            check("retrip phase", outs, 4'b0100);
            rd_reg(8'h1C, d);
            check("retrip events", d, 32'h14);
            wait_lvl(0, 1'b1, n);
            check("no backup", outs, 4'h0);
         end else begin
            check("no retrip", outs, 4'h1);
            // Phase two channel in TRIP, the others idle, backup high, no flags over setting.
            rd_reg(8'h18, d);
            check("status", d, 32'h6110);
            check("masked", irq, 1'b0);
            wr_reg(8'h20, 32'h1);
            chk_irq(1'b1);
            wr_reg(8'h1C, 32'h1F);
            chk_irq(1'b0);
         end
         fault <= 1'b0;
         wait_lvl(0, 1'b0, n);
      end
      $display("test retrip done");
   endtask : t_retrip
   // Residual start with 3I0 first at, then just above, the residual setting.
   task automatic t_residual();
      int n;
      wr_reg(8'h00, {30'h0, OP_CURRENT});
      cur_on <= 1'b0;
      res_cur <= 16'h000A;
      res_start <= 1'b1;
      wait_lvl(0, 1'b1, n);
      check("res equal", outs, 4'h0);
      res_start <= 1'b0;
      res_cur <= 16'h000B;
      @(posedge mclk);
      res_start <= 1'b1;
      wait_lvl(0, 1'b1, n);
      check("res delay", n >= 99 * MS && n <= 103 * MS, 1'b1);
      res_start <= 1'b0;
      wait_lvl(0, 1'b0, n);
      check("res pulse", n >= 98 * MS, 1'b1);
      wr_reg(8'h1C, 32'h1F);
      $display("test residual done");
   endtask : t_residual
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   // Free-running 250 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Reset for three cycles, then every scenario in turn.
   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_modes();
      t_block();
      t_retrip();
      t_residual();
      end_sim();
   end
   // The scenarios take near 20000 cycles; twice that means a hang.
   initial begin
      repeat (40000) @(posedge mclk);
      err_total++;
      end_sim();
   end
endmodule : tb_breaker_failure_decision_logic
